// *** design/pdc_consts.svh ***
// Purpose: field positions, control codes and reset values of the
//          synthesizer programming words
// Assumes: 24-bit words, control code in the low four bits
// Notes:   included by the package and the design modules
`ifndef PDC_CONSTS_SVH
`define PDC_CONSTS_SVH

`define PDC_WORD_W        24
`define PDC_CTRL_MSB      3
// control codes of the decoded words
`define PDC_CODE_MAIN     4'h3
`define PDC_CODE_AUX      4'h5
`define PDC_CODE_OPT      4'h9
// count word: only control_bit_0 identifies it
`define PDC_COUNT_BIT     0
`define PDC_CNT_MSB       23
`define PDC_CNT_LSB       13
`define PDC_FNUM_MSB      12
`define PDC_FNUM_LSB      1
// main divider and power word
`define PDC_MPD_BIT       23
`define PDC_PSEL_BIT      22
`define PDC_FDEN_MSB      21
`define PDC_FDEN_LSB      10
`define PDC_RDIV_MSB      9
`define PDC_RDIV_LSB      4
// aux divider and power word
`define PDC_APD_BIT       23
`define PDC_ACNT_MSB      22
`define PDC_ACNT_LSB      4
// option word
`define PDC_AUTO_POWERUP_ON_COUNT_WRITE_BIT      23
// split of the main count: c [10:5], b [4:2], a [1:0]
`define PDC_C_MSB         10
`define PDC_C_LSB         5
`define PDC_B_MSB         4
`define PDC_B_LSB         2
`define PDC_A_MSB         1
// split of the aux count with the 8/9 prescaler: b [18:3], a [2:0]
`define PDC_AB_MSB        18
`define PDC_AB_LSB        3
`define PDC_AA_MSB        2
// reset values
`define PDC_RST_RDIV      6'h01
`define PDC_RST_PD        1'b1
`define PDC_RST_AUTO_POWERUP_ON_COUNT_WRITE      1'b0

`endif

// *** design/pdc_pkg.sv ***
// Purpose: types shared by the configuration block
// Assumes: constants come from pdc_consts.svh
// Notes:   none
`include "pdc_consts.svh"
package pdc_pkg;
  typedef logic [`PDC_WORD_W-1:0] pdc_word_t;
  typedef enum logic [2:0] {
    PDC_DEST_NONE,
    PDC_DEST_COUNT,
    PDC_DEST_MAIN,
    PDC_DEST_AUX,
    PDC_DEST_OPT
  } pdc_dest_e;
endpackage : pdc_pkg

// *** design/pdc_word_if.sv ***
// Purpose: carries a received programming word to the register bank
// Assumes: valid is a one-cycle pulse on core_clk
// Notes:   none
`timescale 1ns/10ps
interface pdc_word_if;
  import pdc_pkg::*;
  pdc_word_t word;
  logic      valid;
  modport rx  (output word, output valid);
  modport cfg (input word, input valid);
endinterface : pdc_word_if

// *** design/pdc_serial_rx.sv ***
// Purpose: three-wire serial receiver, msb first, latched on enable rise
// Assumes: data is steady around each serial clock rise for >3 core cycles
// Notes:   all pins pass two flip-flops before any logic looks at them
`timescale 1ns/10ps
`include "pdc_consts.svh"
module pdc_serial_rx
  import pdc_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // serial pins
  input  wire logic ser_clk_pin,
  input  wire logic ser_data_pin,
  input  wire logic ser_latch_pin,
  // received words
  pdc_word_if.rx    wout
);
  logic [2:0] s1_reg, s1_next;  // first sync stage {latch, data, clk}
  logic [2:0] s2_reg, s2_next;  // second sync stage
  logic [1:0] d3_reg, d3_next;  // delayed {latch, clk} for edge detect
  pdc_word_t  sh_reg, sh_next;
  pdc_word_t  wd_reg, wd_next;
  logic       vl_reg, vl_next;

  // shift on serial clock rise, hand the word over on latch rise
  always_comb begin
    s1_next = {ser_latch_pin, ser_data_pin, ser_clk_pin};
    s2_next = s1_reg;
    d3_next = {s2_reg[2], s2_reg[0]};
    sh_next = sh_reg;
    wd_next = wd_reg;
    vl_next = 1'b0;
    if (s2_reg[0] && !d3_reg[0]) begin
      sh_next = {sh_reg[`PDC_WORD_W-2:0], s2_reg[1]};
    end
    if (s2_reg[2] && !d3_reg[1]) begin
      wd_next = sh_reg;
      vl_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s1_reg <= 3'h0;
      s2_reg <= 3'h0;
      d3_reg <= 2'h0;
      sh_reg <= 24'h000000;
      wd_reg <= 24'h000000;
      vl_reg <= 1'b0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      d3_reg <= d3_next;
      sh_reg <= sh_next;
      wd_reg <= wd_next;
      vl_reg <= vl_next;
    end
  end

  assign wout.word  = wd_reg;
  assign wout.valid = vl_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // a word is handed over only one cycle after a latch rise
  valid_pulse_a : assert property (vl_reg |->
      !$past(vl_reg) && $past(s2_reg[2]))
    else $error("word handed over without latch rise");
endmodule : pdc_serial_rx

// *** design/pdc_config_top.sv ***
// Purpose: divider and power-down register bank of a dual synthesizer
// Assumes: words arrive over the three-wire serial pins
// Notes:   power-down outputs are registered, two cycles after a word, three after chip enable
`timescale 1ns/10ps
`include "pdc_consts.svh"

// Overview of operation
// - reference divider ratio from six bits, 1..63; a written 0 is passed to main_reference_divider unchecked
// - prescaler bit picks 16/17/20/21 or 32/33/36/37
// - power-down bit 1 stops main loop, pump hi-z
// - chip enable low always powers main loop down
// - auto power-up overrides power-down bit when enabled
// - otherwise power-down bit sets main loop state
// - main count splits into c, b, a fields
// - aux count splits into b, a fields
// - count word known by bit zero alone
// - count write with auto power-up wakes aux loop
module pdc_config_top
  import pdc_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // serial programming pins and chip enable
  input  wire logic        ser_clk_pin,
  input  wire logic        ser_data_pin,
  input  wire logic        ser_latch_pin,
  input  wire logic        chip_enable_pin,
  // main loop settings
  output logic [5:0]       main_reference_divider,
  output logic             main_prescaler_select,
  output logic [10:0]      main_feedback_count,
  output logic [5:0]       main_count_c_field,
  output logic [2:0]       main_count_b_field,
  output logic [1:0]       main_count_a_field,
  output logic [11:0]      main_fraction_numerator,
  output logic [11:0]      main_fraction_denominator,
  // aux loop settings
  output logic [15:0]      aux_count_b_field,
  output logic [2:0]       aux_count_a_field,
  // power state
  output logic             main_loop_powered_down,
  output logic             main_pump_hiz,
  output logic             aux_loop_powered_down,
  output logic             aux_pump_hiz
);
  pdc_word_if wbus ();

  pdc_serial_rx u_rx (
    .core_clk      (core_clk),
    .rstn          (rstn),
    .ser_clk_pin   (ser_clk_pin),
    .ser_data_pin  (ser_data_pin),
    .ser_latch_pin (ser_latch_pin),
    .wout          (wbus.rx)
  );

  // destination of a word from its control bits
  function automatic pdc_dest_e dest_of(input pdc_word_t w);
    if (w[`PDC_COUNT_BIT] == 1'b0) begin
      dest_of = PDC_DEST_COUNT;
    end else begin
      unique case (w[`PDC_CTRL_MSB:0])
        `PDC_CODE_MAIN : dest_of = PDC_DEST_MAIN;
        `PDC_CODE_AUX  : dest_of = PDC_DEST_AUX;
        `PDC_CODE_OPT  : dest_of = PDC_DEST_OPT;
        default        : dest_of = PDC_DEST_NONE;
      endcase
    end
  endfunction : dest_of

  logic        ce_s1_reg, ce_s1_next;   // chip enable sync stage one
  logic        ce_s2_reg, ce_s2_next;   // chip enable sync stage two
  logic [10:0] cnt_reg, cnt_next;
  logic [11:0] fnum_reg, fnum_next;
  logic [11:0] fden_reg, fden_next;
  logic [5:0]  rdiv_reg, rdiv_next;
  logic        psel_reg, psel_next;
  logic        mpd_reg, mpd_next;       // main-loop power-down bit
  logic [18:0] acnt_reg, acnt_next;
  logic        apd_reg, apd_next;       // aux-loop power-down bit
  logic        auto_powerup_on_count_write_reg, auto_powerup_on_count_write_next;     // auto power-up option
  logic        mup_reg, mup_next;       // auto power-up holds main loop up
  logic        mdn_reg, mdn_next;
  logic        adn_reg, adn_next;
  pdc_dest_e   dest;

  assign dest = wbus.valid ? dest_of(wbus.word) : PDC_DEST_NONE;

  // register writes and power-down precedence
  always_comb begin
    ce_s1_next = chip_enable_pin;
    ce_s2_next = ce_s1_reg;
    cnt_next   = cnt_reg;
    fnum_next  = fnum_reg;
    fden_next  = fden_reg;
    rdiv_next  = rdiv_reg;
    psel_next  = psel_reg;
    mpd_next   = mpd_reg;
    acnt_next  = acnt_reg;
    apd_next   = apd_reg;
    auto_powerup_on_count_write_next  = auto_powerup_on_count_write_reg;
    mup_next   = mup_reg;
    unique case (dest)
      PDC_DEST_COUNT : begin
        cnt_next  = wbus.word[`PDC_CNT_MSB:`PDC_CNT_LSB];
        fnum_next = wbus.word[`PDC_FNUM_MSB:`PDC_FNUM_LSB];
        if (auto_powerup_on_count_write_reg) begin
          apd_next = 1'b0;
          mup_next = 1'b1;
        end
      end
      PDC_DEST_MAIN : begin
        mpd_next  = wbus.word[`PDC_MPD_BIT];
        psel_next = wbus.word[`PDC_PSEL_BIT];
        fden_next = wbus.word[`PDC_FDEN_MSB:`PDC_FDEN_LSB];
        rdiv_next = wbus.word[`PDC_RDIV_MSB:`PDC_RDIV_LSB];
        mup_next  = 1'b0;                       // software takes over
      end
      PDC_DEST_AUX : begin
        apd_next  = wbus.word[`PDC_APD_BIT];
        acnt_next = wbus.word[`PDC_ACNT_MSB:`PDC_ACNT_LSB];
      end
      PDC_DEST_OPT : begin
        auto_powerup_on_count_write_next = wbus.word[`PDC_AUTO_POWERUP_ON_COUNT_WRITE_BIT];
      end
      PDC_DEST_NONE : begin
      end
    endcase
    // chip enable first, then auto power-up, then the bit
    mdn_next = !ce_s2_reg || (!mup_reg && mpd_reg);
    adn_next = !ce_s2_reg || apd_reg;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ce_s1_reg <= 1'b0;
      ce_s2_reg <= 1'b0;
      cnt_reg   <= 11'h000;
      fnum_reg  <= 12'h000;
      fden_reg  <= 12'h000;
      rdiv_reg  <= `PDC_RST_RDIV;
      psel_reg  <= 1'b0;
      mpd_reg   <= `PDC_RST_PD;
      acnt_reg  <= 19'h00000;
      apd_reg   <= `PDC_RST_PD;
      auto_powerup_on_count_write_reg  <= `PDC_RST_AUTO_POWERUP_ON_COUNT_WRITE;
      mup_reg   <= 1'b0;
      mdn_reg   <= 1'b1;
      adn_reg   <= 1'b1;
    end else begin
      ce_s1_reg <= ce_s1_next;
      ce_s2_reg <= ce_s2_next;
      cnt_reg   <= cnt_next;
      fnum_reg  <= fnum_next;
      fden_reg  <= fden_next;
      rdiv_reg  <= rdiv_next;
      psel_reg  <= psel_next;
      mpd_reg   <= mpd_next;
      acnt_reg  <= acnt_next;
      apd_reg   <= apd_next;
      auto_powerup_on_count_write_reg  <= auto_powerup_on_count_write_next;
      mup_reg   <= mup_next;
      mdn_reg   <= mdn_next;
      adn_reg   <= adn_next;
    end
  end

  // settings straight from the registers; ratio 0 is never a legal ratio
  assign main_reference_divider    = rdiv_reg;
  assign main_prescaler_select     = psel_reg;
  assign main_feedback_count       = cnt_reg;
  // count ranges are the host's duty and are not checked here
  assign main_count_c_field = cnt_reg[`PDC_C_MSB:`PDC_C_LSB];
  assign main_count_b_field = cnt_reg[`PDC_B_MSB:`PDC_B_LSB];
  assign main_count_a_field = cnt_reg[`PDC_A_MSB:0];
  assign main_fraction_numerator   = fnum_reg;
  assign main_fraction_denominator = fden_reg;
  assign aux_count_b_field = acnt_reg[`PDC_AB_MSB:`PDC_AB_LSB];
  assign aux_count_a_field = acnt_reg[`PDC_AA_MSB:0];
  // a powered-down loop leaves its pump floating
  assign main_loop_powered_down    = mdn_reg;
  assign main_pump_hiz             = mdn_reg;
  assign aux_loop_powered_down     = adn_reg;
  assign aux_pump_hiz              = adn_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  ref_div_load_a : assert property (dest == PDC_DEST_MAIN |=>
      rdiv_reg == $past(wbus.word[`PDC_RDIV_MSB:`PDC_RDIV_LSB]))
    else $error("reference divider not loaded");
  psel_load_a : assert property (dest == PDC_DEST_MAIN |=>
      psel_reg == $past(wbus.word[`PDC_PSEL_BIT]))
    else $error("prescaler select not loaded");
  pd_bit_hiz_a : assert property (ce_s2_reg && !mup_reg && mpd_reg
      |=> main_pump_hiz && main_loop_powered_down)
    else $error("power-down bit did not float pump");
  ce_low_pd_a : assert property (!ce_s2_reg |=> mdn_reg && adn_reg)
    else $error("chip enable low but loop powered");
  auto_up_a : assert property (ce_s2_reg && mup_reg |=> !mdn_reg)
    else $error("auto power-up did not win");
  bit_rules_a : assert property (ce_s2_reg && !mup_reg && !mpd_reg
      |=> !mdn_reg)
    else $error("clear power-down bit left loop down");
  c_split_a : assert property (dest == PDC_DEST_COUNT |=>
      main_count_c_field ==
      $past(wbus.word[`PDC_CNT_LSB+`PDC_C_MSB:`PDC_CNT_LSB+`PDC_C_LSB])
      && main_count_b_field ==
      $past(wbus.word[`PDC_CNT_LSB+`PDC_B_MSB:`PDC_CNT_LSB+`PDC_B_LSB])
      && main_count_a_field ==
      $past(wbus.word[`PDC_CNT_LSB+`PDC_A_MSB:`PDC_CNT_LSB]))
    else $error("main count split wrong");
  aux_split_a : assert property (dest == PDC_DEST_AUX |=>
      aux_count_b_field ==
      $past(wbus.word[`PDC_ACNT_LSB+`PDC_AB_MSB:`PDC_ACNT_LSB+`PDC_AB_LSB])
      && aux_count_a_field ==
      $past(wbus.word[`PDC_ACNT_LSB+`PDC_AA_MSB:`PDC_ACNT_LSB]))
    else $error("aux count split wrong");
  decode_aux_a : assert property (wbus.valid &&
      wbus.word[3:0] == `PDC_CODE_AUX |=> acnt_reg ==
      $past(wbus.word[`PDC_ACNT_MSB:`PDC_ACNT_LSB]))
    else $error("aux word not decoded");
  count_bit_a : assert property (wbus.valid && !wbus.word[0] |=>
      cnt_reg == $past(wbus.word[`PDC_CNT_MSB:`PDC_CNT_LSB]))
    else $error("count word not taken");
  aux_wake_a : assert property (dest == PDC_DEST_COUNT && auto_powerup_on_count_write_reg
      && ce_s2_reg ##1 dest != PDC_DEST_AUX && ce_s2_reg |=> !adn_reg)
    else $error("aux loop not woken by count write");

  count_write_c : cover property (dest == PDC_DEST_COUNT);
  auto_wake_c   : cover property (dest == PDC_DEST_COUNT && auto_powerup_on_count_write_reg);
  ce_drop_c     : cover property (ce_s2_reg ##1 !ce_s2_reg);
  main_write_c  : cover property (dest == PDC_DEST_MAIN && psel_next);
endmodule : pdc_config_top

// *** verif/pdc_host_model.sv ***
// Purpose: host side that shifts programming words into the serial pins
// Assumes: one word per start pulse, msb first, five core cycles per phase
// Notes:   serial clock stands low between frames
`timescale 1ns/10ps
module pdc_host_model (
  // clock
  input  wire logic        core_clk,
  // word request
  input  wire logic [23:0] word,
  input  wire logic        start,
  output logic             done,
  // serial pins
  output logic             ser_clk_pin,
  output logic             ser_data_pin,
  output logic             ser_latch_pin
);
  logic [23:0] sh;

  // one frame per start; released data shows the inverse of its last bit
  initial begin
    {done, ser_clk_pin, ser_data_pin, ser_latch_pin} = 4'h0;
    forever begin
      @(posedge core_clk);
      done <= 1'h0;
      if (start) begin
        sh = word;
        for (int i = 23; i >= 0; i--) begin
          ser_clk_pin  <= 1'h0;
          ser_data_pin <= sh[i];
          repeat (5) @(posedge core_clk);
          ser_clk_pin <= 1'h1;
          repeat (5) @(posedge core_clk);
        end
        ser_clk_pin   <= 1'h0;
        ser_data_pin  <= ~sh[0];
        ser_latch_pin <= 1'h1;
        repeat (5) @(posedge core_clk);
        ser_latch_pin <= 1'h0;
        done          <= 1'h1;
      end
    end
  end
endmodule : pdc_host_model

// *** verif/tb_top.sv ***
// Purpose: self-checking bench of the divider and power register bank
// Assumes: outputs settle within four cycles after the latch falls
// Notes:   words with unknown codes double as probes of the power state
`timescale 1ns/10ps
`include "pdc_consts.svh"
module tb_top;
  import pdc_pkg::*;
  typedef struct {
    logic [5:0]  rdiv;
    logic        psel;
    logic [10:0] cnt;
    logic [11:0] num;
    logic [11:0] den;
    logic [18:0] acnt;
    logic        mpd;
    logic        apd;
  } pdc_exp_s;
  logic        core_clk, rstn, chip_enable_pin, start, done;
  logic        ser_clk_pin, ser_data_pin, ser_latch_pin;
  pdc_word_t   word;
  logic [5:0]  main_reference_divider, main_count_c_field;
  logic        main_prescaler_select, main_loop_powered_down, main_pump_hiz;
  logic        aux_loop_powered_down, aux_pump_hiz;
  logic [10:0] main_feedback_count;
  logic [2:0]  main_count_b_field, aux_count_a_field;
  logic [1:0]  main_count_a_field;
  logic [11:0] main_fraction_numerator, main_fraction_denominator;
  logic [15:0] aux_count_b_field;
  pdc_exp_s    e, q[$];
  logic        mpd_bit, apd_bit, auto_powerup_on_count_write, held;
  int          fails, total_checks;

  pdc_config_top i_pdc_config_top (
    .core_clk, .rstn, .ser_clk_pin, .ser_data_pin, .ser_latch_pin,
    .chip_enable_pin, .main_reference_divider, .main_prescaler_select,
    .main_feedback_count, .main_count_c_field, .main_count_b_field,
    .main_count_a_field, .main_fraction_numerator,
    .main_fraction_denominator, .aux_count_b_field, .aux_count_a_field,
    .main_loop_powered_down, .main_pump_hiz, .aux_loop_powered_down,
    .aux_pump_hiz);
  pdc_host_model i_pdc_host_model (
    .core_clk, .word, .start, .done, .ser_clk_pin, .ser_data_pin,
    .ser_latch_pin);

  // 125 MHz core clock
  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  // sends one word and notes the outputs it should leave behind
  task automatic wr(input pdc_word_t w);
    int n;
    @(posedge core_clk);
    word  <= w;
    start <= 1'h1;
    e.mpd = !chip_enable_pin | (!held & mpd_bit);
    e.apd = !chip_enable_pin | apd_bit;
    q.push_back(e);
    @(posedge core_clk);
    start <= 1'h0;
    n = 0;
    while (done !== 1'h1 && n < 400) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 400) begin
      fails++;
      $display("CHECK FAILED t=%0t host gave no done", $time);
    end
    repeat (8) @(posedge core_clk);
  endtask : wr

  task automatic wr_main;
    held = 1'h0;
    wr({mpd_bit, e.psel, e.den, e.rdiv, `PDC_CODE_MAIN});
  endtask : wr_main

  task automatic wr_cnt;
    if (auto_powerup_on_count_write) begin
      held    = 1'h1;
      apd_bit = 1'h0;
    end
    wr({e.cnt, e.num, 1'h0});
  endtask : wr_cnt

  task automatic chk(input pdc_exp_s x);
    total_checks++;
    if (main_reference_divider !== x.rdiv || main_prescaler_select !== x.psel
      || main_feedback_count !== x.cnt || main_fraction_numerator !== x.num
      || main_count_c_field !== x.cnt[10:5]
      || main_count_b_field !== x.cnt[4:2] || main_count_a_field !== x.cnt[1:0]
      || main_fraction_denominator !== x.den
      || aux_count_b_field !== x.acnt[18:3]
      || aux_count_a_field !== x.acnt[2:0]
      || main_loop_powered_down !== x.mpd || main_pump_hiz !== x.mpd
      || aux_loop_powered_down !== x.apd || aux_pump_hiz !== x.apd) begin
      fails++;
      $display("CHECK FAILED t=%0t outputs differ from expected", $time);
    end
  endtask : chk

  // takes the oldest note once a word has landed
  initial begin
    forever begin
      @(posedge core_clk);
      if (done === 1'h1) begin
        repeat (4) @(posedge core_clk);
        chk(q.pop_front());
      end
    end
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    end_of_test();
  end

  // main sequence
  initial begin
    rstn = 1'h0;
    chip_enable_pin = 1'h1;
    start = 1'h0;
    word = 24'h000000;
    fails = 0;
    total_checks = 0;
    e = '{6'h01, 1'h0, 11'h000, 12'h000, 12'h000, 19'h00000, 1'h1, 1'h1};
    {mpd_bit, apd_bit, auto_powerup_on_count_write, held} = 4'hC;
    void'($urandom(32'h99A0));
    repeat (8) @(posedge core_clk);
    rstn <= 1'h1;
    wr({20'($urandom), 4'hF});
    for (int k = 0; k < 4; k++) begin
      e.rdiv  = k[0] ? 6'h3F : 6'h01;
      e.psel  = k[1];
      e.den   = 12'($urandom);
      mpd_bit = 1'h0;
      wr_main();
    end
    mpd_bit = 1'h1;
    wr_main();
    for (int k = 0; k < 4; k++) begin
      e.cnt = k == 0 ? 11'h061 : k == 1 ? 11'h7FD
            : 11'($urandom_range(32'h7FD, 32'h61));
      e.num = 12'($urandom);
      wr_cnt();
    end
    for (int k = 0; k < 2; k++) begin
      e.acnt  = 19'($urandom);
      apd_bit = 1'(k);
      wr({apd_bit, e.acnt, `PDC_CODE_AUX});
    end
    auto_powerup_on_count_write = 1'h1;
    wr({auto_powerup_on_count_write, 19'h00000, `PDC_CODE_OPT});
    e.cnt = 11'h0E7;
    wr_cnt();
    wr_main();
    chip_enable_pin <= 1'h0;
    wr_cnt();
    chip_enable_pin <= 1'h1;
    wr({20'h00000, 4'h7});
    end_of_test();
  end
endmodule : tb_top
